// file: src/fre_unit.sv
// Purpose: Rounding, zero substitution and exception flags of the FPU
// Assumes: Pipeline hands over exact, normalised results with guard/sticky
// Notes:   One instruction per cycle; result and flags land on one edge
// Function
// [RL1] Mode from status bits 25:24, four encodings
// [RL2] Nearest is default, reset selects it
// [RL3] Toward plus: nearest value not below
// [RL4] Toward minus: nearest value not above
// [RL5] Toward zero truncates magnitude
// [RL6] Flag update writes the rounding mode
// [RL7] Round first, then denormals become signed zero
// [RL8] Fused ops rounded once after add
// [RL9] Call return keeps mode; exception/monitor restore
// [RL10] Nearest ties go to even lsb
// [RL11] Ties across exponents take larger exponent
// [RL12] Tiny results round on denormal grid
// [RL13] Directed modes still flush denormals to zero
// [RL14] Detect five exceptions, set matching flags
// [RL15] Five exception flags are sticky
// [RL16] Flag update clears exception flags
// [RL17] Optional asynchronous trap event, no synchronous traps
// [RL18] Flags at bits 30..26, integer writes overwrite
// [RL19] Any-exception flag tracks each instruction
// [RL20] One major flag; overflow/underflow imply inexact
// [RL21] Flags and result take effect together
`timescale 1ns/1ps
module fre_unit (
   // Clock and reset
   input  wire logic               core_clk,
   input  wire logic               sys_rst,
   // Floating-point result to round
   input  wire logic               op_valid,
   input  wire fre_pkg::fre_op_t   op_in,
   // flag_update_instruction: masked write of status bits 31:24
   input  wire logic               upd_valid,
   input  wire logic [7:0]         upd_mask,
   input  wire logic [7:0]         upd_value,
   // Integer flag write of status bits 31:26
   input  wire logic               alu_flag_valid,
   input  wire logic [5:0]         alu_flag_value,
   // Return instructions
   input  wire logic               call_return_instruction,
   input  wire logic               exception_return_instruction,
   input  wire logic               monitor_return_instruction,
   input  wire logic [1:0]         rm_restore,
   // Write-back
   output      logic               res_valid_ff,
   output      logic [31:0]        res_data_ff,
   output      logic [7:0]         psw_bits_ff,
   output      logic               exc_event_ff
);
   import fre_pkg::*;

   logic               any_ret_restore;
   fre_rm_t            cur_mode;
   logic signed [10:0] exp_b;
   logic signed [10:0] one_minus;
   logic               tiny;
   logic [4:0]         shamt;
   logic [25:0]        shr_out;
   logic [23:0]        sig;
   logic               g_bit;
   logic               s_bit;
   logic               round_inc;
   logic [24:0]        sum;
   logic signed [10:0] exp_r;
   logic [22:0]        frac_r;
   logic               flush;
   logic [31:0]        packed_data;
   logic               pack_ovf;
   logic [31:0]        nxt_res_data;
   fre_flags_t         nxt_flags;
   logic               nxt_any;
   logic [7:0]         nxt_psw;
   fre_flags_t         res_flags_ff;

   // Shift right keeping every bit lost as sticky
   function automatic logic [25:0] shr_sticky(input logic [24:0] v,
                                              input logic        s,
                                              input logic [4:0]  n);
      logic [49:0] w;
      w = {v, 25'h0000000} >> n;
      return {w[49:25], s | (|w[24:0])};
   endfunction

   // [RL1] The mode in force is the status field of the previous edge
   assign cur_mode = fre_rm_t'(psw_bits_ff[FRE_RM_HI:FRE_RM_LO]);

   // Tiny values are shifted onto the denormal grid before rounding
   always_comb begin
      exp_b     = 11'(op_in.exp) + FRE_BIAS;
      one_minus = FRE_EXP_MIN - exp_b;
      tiny      = ~op_in.is_zero & (exp_b < FRE_EXP_MIN);     // [RL14]
      if (!tiny) begin
         shamt = 5'h00;
      end else if (one_minus > 11'(FRE_SH_MAX)) begin
         shamt = FRE_SH_MAX;
      end else begin
         shamt = one_minus[4:0];
      end
      // [RL8] Fused results arrive exact; rounding happens here only
      shr_out = shr_sticky({op_in.mant, op_in.grd}, op_in.stk, shamt);
      sig     = shr_out[25:2];
      g_bit   = shr_out[1];
      s_bit   = shr_out[0];
   end

   fre_round_inc u_round_inc (
      .sign (op_in.sign),
      .lsb  (sig[0]),
      .grd  (g_bit),
      .stk  (s_bit),
      .mode (cur_mode),
      .inc  (round_inc)
   );

   always_comb begin
      sum = {1'b0, sig} + {24'h000000, round_inc};
      if (!tiny) begin
         // [RL11] Carry out moves to the larger exponent, frac zero
         exp_r  = exp_b + {10'h000, sum[24]};
         frac_r = sum[24] ? FRE_FRAC_NIL : sum[22:0];
         flush  = 1'b0;
      end else begin
         // [RL12] Only a carry into the hidden bit reaches min normal
         exp_r  = FRE_EXP_MIN;
         frac_r = sum[22:0];
         flush  = ~sum[23];                                   // [RL13]
      end
   end

   fre_pack u_pack (
      .sign  (op_in.sign),
      .exp_b (exp_r),
      .frac  (frac_r),
      .flush (flush),
      .mode  (cur_mode),
      .data  (packed_data),
      .ovf   (pack_ovf)
   );

   // Specials first, then the rounded path
   always_comb begin
      nxt_flags = '0;
      if (op_in.invalid) begin
         nxt_res_data  = op_in.qnan;
         nxt_flags.inv = 1'b1;                                // [RL14]
      end else if (op_in.div_zero) begin
         nxt_res_data  = {op_in.sign, FRE_EXP_ALL1, FRE_FRAC_NIL};
         nxt_flags.dz  = 1'b1;                                // [RL14]
      end else if (op_in.is_inf) begin
         nxt_res_data  = {op_in.sign, FRE_EXP_ALL1, FRE_FRAC_NIL};
      end else if (op_in.is_zero) begin
         nxt_res_data  = {op_in.sign, 31'h0000_0000};
      end else begin
         nxt_res_data  = packed_data;
         nxt_flags.unf = tiny;                                // [RL14]
         nxt_flags.ovf = pack_ovf & ~tiny;                    // [RL20]
         // [RL20] Overflow and underflow always lose accuracy
         nxt_flags.inx = g_bit | s_bit | tiny | pack_ovf;
      end
      nxt_any = |nxt_flags;
   end

   assign any_ret_restore = exception_return_instruction |
                            monitor_return_instruction;

   // Next status bits: writes first, hardware sets last so they win
   always_comb begin
      nxt_psw = psw_bits_ff;
      if (upd_valid) begin
         // [RL6] [RL16] Masked write reaches mode and flags alike
         nxt_psw = (psw_bits_ff & ~upd_mask) | (upd_value & upd_mask);
      end
      if (any_ret_restore) begin
         nxt_psw[FRE_RM_HI:FRE_RM_LO] = rm_restore;           // [RL9]
      end
      if (alu_flag_valid) begin
         nxt_psw[FRE_FS_IDX:FRE_FX_IDX] = alu_flag_value;     // [RL18]
      end
      if (op_valid) begin
         // [RL15] A floating-point instruction only ever raises them, never clears them
         nxt_psw[FRE_FI_IDX] = nxt_psw[FRE_FI_IDX] | nxt_flags.inv;
         nxt_psw[FRE_FV_IDX] = nxt_psw[FRE_FV_IDX] | nxt_flags.ovf;
         nxt_psw[FRE_FZ_IDX] = nxt_psw[FRE_FZ_IDX] | nxt_flags.dz;
         nxt_psw[FRE_FU_IDX] = nxt_psw[FRE_FU_IDX] | nxt_flags.unf;
         nxt_psw[FRE_FX_IDX] = nxt_psw[FRE_FX_IDX] | nxt_flags.inx;
         nxt_psw[FRE_FS_IDX] = nxt_any;                       // [RL19]
      end
   end

   // Status bits; reset selects round to nearest
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         psw_bits_ff <= FRE_PSW_RST;                          // [RL2]
      end else begin
         psw_bits_ff <= nxt_psw;                              // [RL21]
      end
   end

   // Result write-back on the same edge as the flags
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         res_valid_ff <= 1'b0;
         res_data_ff  <= FRE_RES_RST;
         res_flags_ff <= '0;
      end else begin
         res_valid_ff <= op_valid;                            // [RL21]
         if (op_valid) begin
            res_data_ff  <= nxt_res_data;
            res_flags_ff <= nxt_flags;
         end
      end
   end

   // One-cycle event for an asynchronous trap after completion
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         exc_event_ff <= 1'b0;
      end else begin
         exc_event_ff <= op_valid & nxt_any;                  // [RL17]
      end
   end

   // Checks
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (sys_rst);

   sequence s_fp_issue;
      op_valid && !upd_valid && !alu_flag_valid;
   endsequence

   sequence s_wb_seen;
      res_valid_ff && (exc_event_ff == (|res_flags_ff));
   endsequence

   AST_WB_SAME_EDGE: assert property ( // [RL21]
      s_fp_issue |=> s_wb_seen ##0
         (psw_bits_ff[FRE_FS_IDX] == (|res_flags_ff)))
      else $error("result, flags and event not written together");

   AST_STICKY_HOLD: assert property ( // [RL15]
      s_fp_issue |=>
         ((psw_bits_ff[FRE_FI_IDX:FRE_FX_IDX] &
           $past(psw_bits_ff[FRE_FI_IDX:FRE_FX_IDX])) ==
          $past(psw_bits_ff[FRE_FI_IDX:FRE_FX_IDX])))
      else $error("sticky exception flag dropped");

   AST_FLAG_SET: assert property ( // [RL14]
      s_fp_issue ##1 res_valid_ff |->
         ((psw_bits_ff[FRE_FI_IDX:FRE_FX_IDX] & res_flags_ff) ==
          res_flags_ff))
      else $error("raised exception not visible in status bits");

   AST_ONE_MAJOR: assert property ( // [RL20]
      res_valid_ff |->
         $onehot0({res_flags_ff.inv, res_flags_ff.ovf,
                   res_flags_ff.dz, res_flags_ff.unf}))
      else $error("more than one major exception in one operation");

   AST_OV_UF_INEXACT: assert property ( // [RL20]
      res_valid_ff && (res_flags_ff.ovf || res_flags_ff.unf) |->
         res_flags_ff.inx)
      else $error("overflow or underflow without inexact");

   AST_NO_DENORMAL: assert property ( // [RL7]
      res_valid_ff && !res_flags_ff.inv |->
         !((res_data_ff[30:23] == 8'h00) && (res_data_ff[22:0] != 23'h0)))
      else $error("denormal result escaped");

   AST_RTZ_TRUNC: assert property ( // [RL5]
      op_valid && (cur_mode == FRE_RM_ZERO) |-> !round_inc)
      else $error("toward-zero mode incremented");

   AST_TIE_EVEN: assert property ( // [RL10]
      op_valid && (cur_mode == FRE_RM_NEAREST) && g_bit && !s_bit |->
         (sum[0] == 1'b0))
      else $error("nearest tie left odd lsb");

   AST_CALL_KEEP: assert property ( // [RL9]
      call_return_instruction && !any_ret_restore && !upd_valid |=>
         $stable(psw_bits_ff[FRE_RM_HI:FRE_RM_LO]))
      else $error("call return changed the rounding mode");

   AST_RM_RESTORE: assert property ( // [RL9]
      any_ret_restore |=>
         (psw_bits_ff[FRE_RM_HI:FRE_RM_LO] == $past(rm_restore)))
      else $error("rounding mode not restored on return");

   AST_UPD_WRITE: assert property ( // [RL16]
      upd_valid && !op_valid && !alu_flag_valid && !any_ret_restore |=>
         (psw_bits_ff == (($past(psw_bits_ff) & ~$past(upd_mask)) |
                          ($past(upd_value) & $past(upd_mask)))))
      else $error("flag update write not applied");

   AST_ALU_OVERWRITE: assert property ( // [RL18]
      alu_flag_valid && !op_valid |=>
         (psw_bits_ff[FRE_FS_IDX:FRE_FX_IDX] == $past(alu_flag_value)))
      else $error("integer flag write did not overwrite");

   sequence s_rounded_issue;
      op_valid && !op_in.invalid && !op_in.div_zero &&
         !op_in.is_inf && !op_in.is_zero;
   endsequence

   AST_PLUS_UP: assert property ( // [RL3]
      s_rounded_issue ##0 ((cur_mode == FRE_RM_PLUS) &&
         !op_in.sign && (g_bit || s_bit)) |-> round_inc)
      else $error("toward-plus mode kept a positive value low");

   AST_MINUS_UP: assert property ( // [RL4]
      s_rounded_issue ##0 ((cur_mode == FRE_RM_MINUS) &&
         op_in.sign && (g_bit || s_bit)) |-> round_inc)
      else $error("toward-minus mode kept a negative value high");

   AST_DIRECTED_TRUNC: assert property ( // [RL3] [RL4]
      s_rounded_issue ##0 (((cur_mode == FRE_RM_PLUS) && op_in.sign) ||
         ((cur_mode == FRE_RM_MINUS) && !op_in.sign)) |-> !round_inc)
      else $error("directed mode moved away from its direction");

   AST_CARRY_UP: assert property ( // [RL11]
      s_rounded_issue ##0 (!tiny && sum[24]) |->
         ((exp_r == (exp_b + 11'sh001)) && (frac_r == FRE_FRAC_NIL)))
      else $error("rounding carry did not move to the next exponent");

   AST_TINY_TO_MIN: assert property ( // [RL12]
      s_rounded_issue ##0 (tiny && sum[23]) |=>
         (res_data_ff[30:0] == {8'h01, FRE_FRAC_NIL}))
      else $error("tiny value rounded up did not give min normal");

   AST_TINY_FLUSH: assert property ( // [RL7] [RL13]
      s_rounded_issue ##0 (tiny && !sum[23]) |=>
         (res_data_ff == {$past(op_in.sign), 31'h0000_0000}))
      else $error("denormal result not replaced by signed zero");

   AST_TINY_UNDERFLOW: assert property ( // [RL14]
      s_rounded_issue ##0 tiny |=>
         (res_flags_ff.unf && res_flags_ff.inx))
      else $error("tiny result without underflow and inexact");

   AST_EVENT_WITH_RESULT: assert property ( // [RL17]
      exc_event_ff |-> res_valid_ff)
      else $error("trap event without a completed instruction");

endmodule // fre_unit

// file: inc/fre_pkg.sv
// Purpose: Shared constants and carriers of the float rounding and flag unit
// Assumes: Single-precision format; status-word bits 31:24 held as 8 bits
// Notes:   Index constants address the 8-bit slice of the status word
package fre_pkg;

   // Rounding-mode encodings of the round_mode_field
   typedef enum logic [1:0] {
      FRE_RM_NEAREST = 2'h0,
      FRE_RM_PLUS    = 2'h1,
      FRE_RM_MINUS   = 2'h2,
      FRE_RM_ZERO    = 2'h3
   } fre_rm_t;

   // Positions inside processor_status_word[31:24]
   localparam int FRE_FS_IDX = 7;
   localparam int FRE_FI_IDX = 6;
   localparam int FRE_FV_IDX = 5;
   localparam int FRE_FZ_IDX = 4;
   localparam int FRE_FU_IDX = 3;
   localparam int FRE_FX_IDX = 2;
   localparam int FRE_RM_HI  = 1;
   localparam int FRE_RM_LO  = 0;
   localparam int FRE_PSW_LSB = 24;

   // Values after reset
   localparam logic [7:0]  FRE_PSW_RST  = 8'h00;
   localparam logic [31:0] FRE_RES_RST  = 32'h0000_0000;

   // Format constants
   localparam logic signed [10:0] FRE_BIAS     = 11'sh07F;
   localparam logic signed [10:0] FRE_EXP_OVF  = 11'sh0FF;
   localparam logic signed [10:0] FRE_EXP_MIN  = 11'sh001;
   localparam logic [4:0]         FRE_SH_MAX   = 5'h19;
   localparam logic [7:0]         FRE_EXP_ALL1 = 8'hFF;
   localparam logic [7:0]         FRE_EXP_MAXF = 8'hFE;
   localparam logic [22:0]        FRE_FRAC_ONE = 23'h7FFFFF;
   localparam logic [22:0]        FRE_FRAC_NIL = 23'h000000;

   // Exact result handed over by the datapath, normalised: mant[23] is 1
   typedef struct packed {
      logic               fused;
      logic               sign;
      logic signed [9:0]  exp;
      logic [23:0]        mant;
      logic               grd;
      logic               stk;
      logic               is_zero;
      logic               is_inf;
      logic               invalid;
      logic               div_zero;
      logic [31:0]        qnan;
   } fre_op_t;

   // Exception flags of one instruction
   typedef struct packed {
      logic inv;
      logic ovf;
      logic dz;
      logic unf;
      logic inx;
   } fre_flags_t;

endpackage

// file: src/fre_round_inc.sv
// Purpose: Decide whether the kept significand is incremented
// Assumes: Guard and sticky already gathered below the kept lsb
// Notes:   Pure combinational
`timescale 1ns/1ps
module fre_round_inc (
   // Operand position
   input  wire logic            sign,
   input  wire logic            lsb,
   input  wire logic            grd,
   input  wire logic            stk,
   // Mode
   input  wire fre_pkg::fre_rm_t mode,
   // Decision
   output      logic            inc
);
   import fre_pkg::*;

   always_comb begin
      case (mode)
         FRE_RM_NEAREST: inc = grd & (stk | lsb);   // [RL10] [RL11]
         FRE_RM_PLUS:    inc = ~sign & (grd | stk); // [RL3]
         FRE_RM_MINUS:   inc = sign & (grd | stk);  // [RL4]
         default:        inc = 1'b0;                // [RL5]
      endcase
   end

endmodule // fre_round_inc

// file: src/fre_pack.sv
// Purpose: Pack a rounded result, apply overflow and zero substitution
// Assumes: Exponent is biased and already includes the rounding carry
// Notes:   Pure combinational
`timescale 1ns/1ps
module fre_pack (
   // Rounded value
   input  wire logic               sign,
   input  wire logic signed [10:0] exp_b,
   input  wire logic [22:0]        frac,
   input  wire logic               flush,
   // Mode
   input  wire fre_pkg::fre_rm_t   mode,
   // Packed word
   output      logic [31:0]        data,
   output      logic               ovf
);
   import fre_pkg::*;

   logic to_inf;

   always_comb begin
      ovf = ~flush & (exp_b >= FRE_EXP_OVF);
      case (mode)
         FRE_RM_NEAREST: to_inf = 1'b1;
         FRE_RM_PLUS:    to_inf = ~sign;
         FRE_RM_MINUS:   to_inf = sign;
         default:        to_inf = 1'b0;
      endcase
      if (flush) begin
         data = {sign, 31'h0000_0000};                  // [RL7]
      end else if (ovf && to_inf) begin
         data = {sign, FRE_EXP_ALL1, FRE_FRAC_NIL};
      end else if (ovf) begin
         data = {sign, FRE_EXP_MAXF, FRE_FRAC_ONE};
      end else begin
         data = {sign, exp_b[7:0], frac};
      end
   end

endmodule // fre_pack

// file: dv/fre_pipe_model.sv
// Purpose: Instruction pipeline stand-in that feeds the rounding unit
// Assumes: One request per task call, driven 1 ns after a rising edge
// Notes:   Released buses show the inverse of the last value
`timescale 1ns/1ps
module fre_pipe_model (
   // Clock
   input  wire logic             core_clk,
   // Result to round
   output      logic             op_valid,
   output      fre_pkg::fre_op_t op_in,
   // Status writes
   output      logic             upd_valid,
   output      logic [7:0]       upd_mask,
   output      logic [7:0]       upd_value,
   output      logic             alu_flag_valid,
   output      logic [5:0]       alu_flag_value,
   // Returns
   output      logic             call_return_instruction,
   output      logic             exception_return_instruction,
   output      logic             monitor_return_instruction,
   output      logic [1:0]       rm_restore
);
   import fre_pkg::*;

   initial begin
      op_valid = 1'b0;
      op_in = '0;
      upd_valid = 1'b0;
      upd_mask = 8'h00;
      upd_value = 8'h00;
      alu_flag_valid = 1'b0;
      alu_flag_value = 6'h00;
      call_return_instruction = 1'b0;
      exception_return_instruction = 1'b0;
      monitor_return_instruction = 1'b0;
      rm_restore = 2'h0;
   end

   task automatic issue(input fre_op_t o);
      @(posedge core_clk);
      #1 op_valid = 1'b1;
      op_in = o;
      @(posedge core_clk);
      #1 op_valid = 1'b0;
      op_in = ~o;
   endtask

   task automatic upd(input logic [7:0] m, input logic [7:0] v);
      @(posedge core_clk);
      #1 upd_valid = 1'b1;
      upd_mask = m;
      upd_value = v;
      @(posedge core_clk);
      #1 upd_valid = 1'b0;
      upd_mask = ~m;
      upd_value = ~v;
   endtask

   task automatic alu(input logic [5:0] v);
      @(posedge core_clk);
      #1 alu_flag_valid = 1'b1;
      alu_flag_value = v;
      @(posedge core_clk);
      #1 alu_flag_valid = 1'b0;
      alu_flag_value = ~v;
   endtask

   // Kind 0 call, 1 exception, 2 monitor return
   task automatic ret(input int kind, input logic [1:0] rm);
      @(posedge core_clk);
      #1 call_return_instruction = (kind == 0);
      exception_return_instruction = (kind == 1);
      monitor_return_instruction = (kind == 2);
      rm_restore = rm;
      @(posedge core_clk);
      #1 call_return_instruction = 1'b0;
      exception_return_instruction = 1'b0;
      monitor_return_instruction = 1'b0;
      rm_restore = ~rm;
   endtask
endmodule // fre_pipe_model

// file: dv/fre_tb.sv
// Purpose: Self-checking bench of the rounding and flag unit
// Assumes: Result and status land one edge after the request
// Notes:   Expected status word is tracked beside the design
`timescale 1ns/1ps
module tb;
   import fre_pkg::*;

   logic             core_clk;
   logic             sys_rst;
   logic             op_valid;
   fre_op_t          op_in;
   logic             upd_valid;
   logic [7:0]       upd_mask;
   logic [7:0]       upd_value;
   logic             alu_flag_valid;
   logic [5:0]       alu_flag_value;
   logic             call_ret;
   logic             exc_ret;
   logic             mon_ret;
   logic [1:0]       rm_restore;
   logic             res_valid_ff;
   logic [31:0]      res_data_ff;
   logic [7:0]       psw_bits_ff;
   logic             exc_event_ff;
   logic [7:0]       exp_psw;
   int               fails;
   int               compares;

   fre_pipe_model pipe (.core_clk(core_clk), .op_valid(op_valid),
      .op_in(op_in), .upd_valid(upd_valid), .upd_mask(upd_mask),
      .upd_value(upd_value), .alu_flag_valid(alu_flag_valid),
      .alu_flag_value(alu_flag_value), .call_return_instruction(call_ret),
      .exception_return_instruction(exc_ret),
      .monitor_return_instruction(mon_ret), .rm_restore(rm_restore));

   fre_unit dut (.core_clk(core_clk), .sys_rst(sys_rst),
      .op_valid(op_valid), .op_in(op_in), .upd_valid(upd_valid),
      .upd_mask(upd_mask), .upd_value(upd_value),
      .alu_flag_valid(alu_flag_valid), .alu_flag_value(alu_flag_value),
      .call_return_instruction(call_ret),
      .exception_return_instruction(exc_ret),
      .monitor_return_instruction(mon_ret), .rm_restore(rm_restore),
      .res_valid_ff(res_valid_ff), .res_data_ff(res_data_ff),
      .psw_bits_ff(psw_bits_ff), .exc_event_ff(exc_event_ff));

   always #25 core_clk = ~core_clk;

   task automatic end_of_test();
      if (fails == 0 && compares > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   task automatic chk_res(input logic [31:0] g, input logic [31:0] e);
      compares++;
      if (g !== e) begin
         fails++;
         $display("MISMATCH %0t result got %h exp %h", $time, g, e);
      end
   endtask

   task automatic chk_psw();
      compares++;
      if (psw_bits_ff !== exp_psw) begin
         fails++;
         $display("MISMATCH %0t status got %h exp %h", $time,
                  psw_bits_ff, exp_psw);
      end
   endtask

   task automatic chk_bit(input logic g, input logic e, input string m);
      compares++;
      if (g !== e) begin
         fails++;
         $display("MISMATCH %0t %s got %b exp %b", $time, m, g, e);
      end
   endtask

   function automatic fre_op_t mk(input logic s, input logic [9:0] e,
                                  input logic [23:0] m, input logic g,
                                  input logic k);
      fre_op_t o;
      o = '0;
      o.sign = s;
      o.exp = e;
      o.mant = m;
      o.grd = g;
      o.stk = k;
      return o;
   endfunction

   // Flags are inv,ovf,dz,unf,inx
   task automatic op_chk(input fre_op_t o, input logic [31:0] er,
                         input logic [4:0] f);
      pipe.issue(o);
      exp_psw[6:2] = exp_psw[6:2] | f;
      exp_psw[7] = |f;
      chk_bit(res_valid_ff, 1'b1, "valid");
      chk_res(res_data_ff, er);
      chk_psw();
      chk_bit(exc_event_ff, |f, "event");
      @(posedge core_clk);
      #1 chk_bit(res_valid_ff, 1'b0, "valid drop");
      chk_bit(exc_event_ff, 1'b0, "event drop");
   endtask

   task automatic set_mode(input logic [1:0] m);
      pipe.upd(8'h03, {6'h00, m});
      exp_psw[1:0] = m;
      chk_psw();
   endtask

   task automatic t_modes();
      logic [31:0] tbl [4];
      fre_op_t     o;
      tbl = '{32'hBF800002, 32'hBF800001, 32'hBF800002, 32'hBF800001};
      o = mk(1, 10'h000, 24'h800001, 1, 0);
      for (int m = 0; m < 4; m++) begin
         set_mode(m[1:0]);
         op_chk(o, tbl[m], 5'h01);
      end
      set_mode(2'h0);
      op_chk(mk(0, 10'h000, 24'h800000, 1, 0), 32'h3F800000, 5'h01);
      op_chk(mk(0, 10'h000, 24'hFFFFFF, 1, 0), 32'h40000000, 5'h01);
      // Fused result rounded once: guard and sticky both count
      o = mk(0, 10'h000, 24'h800001, 1, 1);
      o.fused = 1'b1;
      op_chk(o, 32'h3F800002, 5'h01);
   endtask

   task automatic t_tiny();
      fre_op_t o;
      // Exponents 381h is -127, 37Eh is -130
      op_chk(mk(0, 10'h381, 24'hFFFFFF, 1, 0), 32'h00800000, 5'h03);
      // Exactly halfway between largest denormal and min normal
      op_chk(mk(0, 10'h381, 24'hFFFFFF, 0, 0), 32'h00800000, 5'h03);
      o = mk(1, 10'h381, 24'h800000, 0, 0);
      op_chk(o, 32'h80000000, 5'h03);
      set_mode(2'h1);
      op_chk(mk(0, 10'h37E, 24'h800000, 0, 1), 32'h00000000, 5'h03);
      set_mode(2'h2);
      op_chk(mk(1, 10'h37E, 24'h800000, 0, 1), 32'h80000000, 5'h03);
   endtask

   task automatic t_exc();
      fre_op_t o;
      op_chk(mk(0, 10'h080, 24'h800000, 0, 0), 32'h7F7FFFFF, 5'h09);
      set_mode(2'h0);
      op_chk(mk(1, 10'h080, 24'h800000, 0, 0), 32'hFF800000, 5'h09);
      o = mk(0, 10'h000, 24'h800000, 0, 0);
      o.invalid = 1'b1;
      o.qnan = 32'h7FC00002;
      op_chk(o, 32'h7FC00002, 5'h10);
      o = mk(1, 10'h000, 24'h800000, 0, 0);
      o.div_zero = 1'b1;
      op_chk(o, 32'hFF800000, 5'h04);
   endtask

   task automatic t_sticky();
      op_chk(mk(0, 10'h000, 24'hC00000, 0, 0), 32'h3FC00000, 5'h00);
      pipe.upd(8'hFC, 8'h00);
      exp_psw[7:2] = 6'h00;
      chk_psw();
      op_chk(mk(0, 10'h000, 24'hC00000, 0, 1), 32'h3FC00000, 5'h01);
   endtask

   task automatic t_ret();
      set_mode(2'h3);
      pipe.ret(0, 2'h1);
      chk_psw();
      pipe.ret(1, 2'h1);
      exp_psw[1:0] = 2'h1;
      chk_psw();
      pipe.ret(2, 2'h2);
      exp_psw[1:0] = 2'h2;
      chk_psw();
      pipe.alu(6'h2A);
      exp_psw[7:2] = 6'h2A;
      chk_psw();
   endtask

   initial begin
      core_clk = 1'b0;
      sys_rst = 1'b1;
      fails = 0;
      compares = 0;
      exp_psw = 8'h00;
      repeat (5) @(posedge core_clk);
      #1 sys_rst = 1'b0;
      chk_psw();
      chk_res(res_data_ff, 32'h00000000);
      t_modes();
      t_tiny();
      t_exc();
      t_sticky();
      t_ret();
      end_of_test();
   end

   // Watchdog cuts a hang short
   initial begin
      repeat (5000) @(posedge core_clk);
      fails++;
      end_of_test();
   end
endmodule // tb
